//--- verilog/cif_flags.sv
`timescale 1ns/10ps
module cif_flags
  import cif_pkg::*;
(
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // protocol engine status
  input wire logic [8:0] tec,
  input wire logic [8:0] rec,
  input wire logic overload_sent,
  input wire logic bit_tick,
  input wire logic rx_bit,
  input wire logic sleep_mode,
  input wire logic standby_entry,
  // mailbox status
  input wire logic [15:0] rx_complete_pulse,
  input wire logic [15:0] rx_remote_pulse,
  input wire logic [15:0] remote_request_reg,
  input wire logic [15:0] receive_complete_reg,
  input wire logic [15:0] unread_status_reg,
  input wire logic [15:0] transmit_pending_reg,
  // interrupt request
  output logic irq
);
  import cif_pkg::*;

  logic [15:0] interrupt_flags;
  logic [15:0] irq_mask_reg;
  logic [15:0] mailbox_irq_mask;
  logic [15:0] txp_prev_reg;
  logic [15:0] unread_prev_reg;
  logic [2:0] rx_sync_reg;
  logic standby_pend_reg;
  logic recovered;
  logic wr_en;
  logic rd_en;
  logic [15:0] wr_lo;
  logic [15:0] w1c;
  logic [15:0] set_ev;
  cif_err_state_t err_state;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  function automatic logic [15:0] lane_mask(input logic [3:0] strb);
    lane_mask = {{8{strb[1]}}, {8{strb[0]}}};
  endfunction : lane_mask

  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;
  assign wr_lo = pwdata[15:0] & lane_mask(pstrb);
  assign w1c = (wr_en && paddr == CIF_ADDR_FLAGS) ? (wr_lo & CIF_W1C_BITS) : 16'h0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      pslverr <= !(paddr == CIF_ADDR_FLAGS || paddr == CIF_ADDR_IRQ_MASK ||
                   paddr == CIF_ADDR_MBOX_MASK || paddr == CIF_ADDR_STATUS || paddr == CIF_ADDR_CTRL);
    end
  end

  // read data registered in setup so it is stable in the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      if (paddr == CIF_ADDR_FLAGS) begin
        prdata <= {16'h0000, interrupt_flags & CIF_FLAGS_USED};
      end else if (paddr == CIF_ADDR_IRQ_MASK) begin
        prdata <= {16'h0000, irq_mask_reg};
      end else if (paddr == CIF_ADDR_MBOX_MASK) begin
        prdata <= {16'h0000, mailbox_irq_mask};
      end else if (paddr == CIF_ADDR_STATUS) begin
        prdata <= {14'h0000, err_state, tec[7:0], rec[7:0]};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // mask registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_reg <= CIF_IRQ_MASK_RST;
    end else if (wr_en && paddr == CIF_ADDR_IRQ_MASK) begin
      irq_mask_reg <= (irq_mask_reg & ~(lane_mask(pstrb) & CIF_IRQ_MASK_RW)) |
                      (wr_lo & CIF_IRQ_MASK_RW) | CIF_IRQ_MASK_RO1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mailbox_irq_mask <= CIF_MBOX_MASK_RST;
    end else if (wr_en && paddr == CIF_ADDR_MBOX_MASK) begin
      mailbox_irq_mask <= (mailbox_irq_mask & ~lane_mask(pstrb)) | wr_lo;
    end
  end

  // ----------------------------------------------------------------
  // error state from counters
  // ----------------------------------------------------------------
  always_comb begin
    if (tec >= CIF_TEC_BUSOFF) begin
      err_state = CIF_ERR_BUSOFF;
    end else if (tec >= CIF_EC_PASSIVE || rec >= CIF_EC_PASSIVE) begin
      err_state = CIF_ERR_PASSIVE;
    end else begin
      err_state = CIF_ERR_ACTIVE;
    end
  end

  // bus pin is asynchronous: three stages, accept when last two agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_sync_reg <= 3'b111;
    end else begin
      rx_sync_reg <= {rx_sync_reg[1:0], rx_bit};
    end
  end

  logic rx_level_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_level_reg <= 1'b1;
    end else if (rx_sync_reg[1] == rx_sync_reg[2]) begin
      rx_level_reg <= rx_sync_reg[2];
    end
  end

  cif_busoff_recovery u_recovery (
    .pclk(pclk),
    .presetn(presetn),
    .in_busoff(err_state == CIF_ERR_BUSOFF),
    .bit_tick(bit_tick),
    .rx_bit(rx_level_reg),
    .recovered(recovered)
  );

  // ----------------------------------------------------------------
  // edge history for mailbox status
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txp_prev_reg <= 16'h0000;
      unread_prev_reg <= 16'h0000;
    end else begin
      txp_prev_reg <= transmit_pending_reg;
      unread_prev_reg <= unread_status_reg;
    end
  end

  // standby reset completes one cycle after the request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      standby_pend_reg <= 1'b0;
    end else begin
      standby_pend_reg <= standby_entry;
    end
  end

  // ----------------------------------------------------------------
  // flag set sources
  // ----------------------------------------------------------------
  always_comb begin
    set_ev = 16'h0000;
    set_ev[CIF_BIT_OVR] = (overload_sent && err_state != CIF_ERR_BUSOFF) || recovered;
    set_ev[CIF_BIT_BOFF] = tec >= CIF_TEC_BUSOFF;
    set_ev[CIF_BIT_EPAS] = tec >= CIF_EC_PASSIVE || rec >= CIF_EC_PASSIVE;
    set_ev[CIF_BIT_RXW] = rec >= CIF_EC_WARN;
    set_ev[CIF_BIT_TXW] = tec >= CIF_EC_WARN;
    set_ev[CIF_BIT_RFR] = |(rx_remote_pulse & ~mailbox_irq_mask);
    set_ev[CIF_BIT_RXM] = |(rx_complete_pulse & ~mailbox_irq_mask);
    set_ev[CIF_BIT_MRST] = standby_pend_reg;
    set_ev[CIF_BIT_WAKE] = sleep_mode && !rx_level_reg;
    set_ev[CIF_BIT_OVW] = |(unread_status_reg & ~unread_prev_reg);
    set_ev[CIF_BIT_MBE] = |(txp_prev_reg & ~transmit_pending_reg);
  end

  // ----------------------------------------------------------------
  // flag register: set wins over clear
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interrupt_flags <= CIF_FLAGS_RST;
    end else begin
      interrupt_flags <= ((interrupt_flags & ~w1c) | set_ev) & CIF_FLAGS_USED;
      if (remote_request_reg == 16'h0000 && !set_ev[CIF_BIT_RFR]) begin
        interrupt_flags[CIF_BIT_RFR] <= 1'b0;
      end
      if ((receive_complete_reg & ~mailbox_irq_mask) == 16'h0000 && !set_ev[CIF_BIT_RXM]) begin
        interrupt_flags[CIF_BIT_RXM] <= 1'b0;
      end
      if (unread_status_reg == 16'h0000) begin
        interrupt_flags[CIF_BIT_OVW] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupt request
  // ----------------------------------------------------------------
  logic [15:0] eff_mask;
  always_comb begin
    eff_mask = irq_mask_reg;
    eff_mask[CIF_BIT_MRST] = 1'b0;
  end
  assign irq = |(interrupt_flags & ~eff_mask);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_bit15_w1c;
    wr_en && paddr == CIF_ADDR_FLAGS && pstrb[1] && pwdata[CIF_BIT_OVR];
  endsequence

  property p_busoff_set;
    @(posedge pclk) disable iff (!presetn) (tec >= CIF_TEC_BUSOFF) |=> interrupt_flags[CIF_BIT_BOFF];
  endproperty
  a_busoff_set: assert property (p_busoff_set) else $error("bus-off flag not set");

  property p_passive_set;
    @(posedge pclk) disable iff (!presetn)
      (rec >= CIF_EC_PASSIVE) |=> interrupt_flags[CIF_BIT_EPAS];
  endproperty
  a_passive_set: assert property (p_passive_set) else $error("error-passive flag not set");

  property p_rxwarn;
    @(posedge pclk) disable iff (!presetn) (rec >= CIF_EC_WARN) |=> interrupt_flags[CIF_BIT_RXW];
  endproperty
  a_rxwarn: assert property (p_rxwarn) else $error("receive warning flag not set");

  property p_txwarn;
    @(posedge pclk) disable iff (!presetn) (tec >= CIF_EC_WARN) |=> interrupt_flags[CIF_BIT_TXW];
  endproperty
  a_txwarn: assert property (p_txwarn) else $error("transmit warning flag not set");

  property p_reserved_zero;
    @(posedge pclk) disable iff (!presetn) (interrupt_flags & ~CIF_FLAGS_USED) == 16'h0000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved flag bit set");

  property p_mrst_irq;
    @(posedge pclk) disable iff (!presetn) interrupt_flags[CIF_BIT_MRST] |-> irq;
  endproperty
  a_mrst_irq: assert property (p_mrst_irq) else $error("module reset flag not requesting");

  property p_mbe_set;
    @(posedge pclk) disable iff (!presetn)
      (|(txp_prev_reg & ~transmit_pending_reg)) |=> interrupt_flags[CIF_BIT_MBE];
  endproperty
  a_mbe_set: assert property (p_mbe_set) else $error("mailbox empty flag not set");

  property p_rfr_clear;
    @(posedge pclk) disable iff (!presetn)
      (remote_request_reg == 16'h0000 && !set_ev[CIF_BIT_RFR]) |=> !interrupt_flags[CIF_BIT_RFR];
  endproperty
  a_rfr_clear: assert property (p_rfr_clear) else $error("remote flag not cleared");

  property p_ovr_w1c;
    @(posedge pclk) disable iff (!presetn)
      s_bit15_w1c and !set_ev[CIF_BIT_OVR] |=> !interrupt_flags[CIF_BIT_OVR];
  endproperty
  a_ovr_w1c: assert property (p_ovr_w1c) else $error("overload flag not cleared by write one");

  // reference built from the mask register itself, module reset forced on
  property p_irq_or;
    @(posedge pclk) disable iff (!presetn)
      irq == (interrupt_flags[CIF_BIT_MRST] || (|(interrupt_flags & ~irq_mask_reg)));
  endproperty
  a_irq_or: assert property (p_irq_or) else $error("interrupt output mismatch");

  property p_rfr_set;
    @(posedge pclk) disable iff (!presetn)
      (|(rx_remote_pulse & ~mailbox_irq_mask)) |=> interrupt_flags[CIF_BIT_RFR];
  endproperty
  a_rfr_set: assert property (p_rfr_set) else $error("remote flag not set");

  property p_rxm_set;
    @(posedge pclk) disable iff (!presetn)
      (|(rx_complete_pulse & ~mailbox_irq_mask)) |=> interrupt_flags[CIF_BIT_RXM];
  endproperty
  a_rxm_set: assert property (p_rxm_set) else $error("receive flag not set");

  property p_rxm_clear;
    @(posedge pclk) disable iff (!presetn)
      ((receive_complete_reg & ~mailbox_irq_mask) == 16'h0000 && !(|(rx_complete_pulse & ~mailbox_irq_mask)))
      |=> !interrupt_flags[CIF_BIT_RXM];
  endproperty
  a_rxm_clear: assert property (p_rxm_clear) else $error("receive flag not cleared");

  property p_ovw_set;
    @(posedge pclk) disable iff (!presetn)
      (|(unread_status_reg & ~unread_prev_reg)) |=> interrupt_flags[CIF_BIT_OVW];
  endproperty
  a_ovw_set: assert property (p_ovw_set) else $error("overwrite flag not set");

  property p_ovw_clear;
    @(posedge pclk) disable iff (!presetn)
      (unread_status_reg == 16'h0000) |=> !interrupt_flags[CIF_BIT_OVW];
  endproperty
  a_ovw_clear: assert property (p_ovw_clear) else $error("overwrite flag not cleared");

  property p_wake_set;
    @(posedge pclk) disable iff (!presetn)
      (sleep_mode && !rx_level_reg) |=> interrupt_flags[CIF_BIT_WAKE];
  endproperty
  a_wake_set: assert property (p_wake_set) else $error("bus activity flag not set");

  // standby request, then one cycle of reset processing
  sequence s_standby_done;
    standby_entry ##1 1'b1;
  endsequence

  property p_mrst_standby;
    @(posedge pclk) disable iff (!presetn) s_standby_done |=> interrupt_flags[CIF_BIT_MRST];
  endproperty
  a_mrst_standby: assert property (p_mrst_standby) else $error("module reset flag not set");

endmodule : cif_flags

//--- verilog/cif_pkg.sv
package cif_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] CIF_ADDR_FLAGS = 12'h000;
  localparam logic [11:0] CIF_ADDR_IRQ_MASK = 12'h004;
  localparam logic [11:0] CIF_ADDR_MBOX_MASK = 12'h008;
  localparam logic [11:0] CIF_ADDR_STATUS = 12'h00c;
  localparam logic [11:0] CIF_ADDR_CTRL = 12'h010;

  // ----------------------------------------------------------------
  // flag bit positions
  // ----------------------------------------------------------------
  localparam int CIF_BIT_OVR = 15;
  localparam int CIF_BIT_BOFF = 14;
  localparam int CIF_BIT_EPAS = 13;
  localparam int CIF_BIT_RXW = 12;
  localparam int CIF_BIT_TXW = 11;
  localparam int CIF_BIT_RFR = 10;
  localparam int CIF_BIT_RXM = 9;
  localparam int CIF_BIT_MRST = 8;
  localparam int CIF_BIT_WAKE = 4;
  localparam int CIF_BIT_OVW = 1;
  localparam int CIF_BIT_MBE = 0;

  // ----------------------------------------------------------------
  // reset values and masks
  // ----------------------------------------------------------------
  localparam logic [15:0] CIF_FLAGS_RST = 16'h0100;
  localparam logic [15:0] CIF_FLAGS_USED = 16'hff13;
  localparam logic [15:0] CIF_W1C_BITS = 16'hf911;
  localparam logic [15:0] CIF_IRQ_MASK_RST = 16'hfeff;
  localparam logic [15:0] CIF_IRQ_MASK_RW = 16'hfe13;
  localparam logic [15:0] CIF_IRQ_MASK_RO1 = 16'h00ec;
  localparam logic [15:0] CIF_MBOX_MASK_RST = 16'hffff;

  // ----------------------------------------------------------------
  // error counter thresholds and recovery counting
  // ----------------------------------------------------------------
  localparam logic [8:0] CIF_TEC_BUSOFF = 9'h100;
  localparam logic [8:0] CIF_EC_PASSIVE = 9'h080;
  localparam logic [8:0] CIF_EC_WARN = 9'h060;
  localparam logic [3:0] CIF_RECESSIVE_RUN = 4'hb;
  localparam logic [7:0] CIF_RECOVERY_RUNS = 8'h80;

  typedef enum logic [1:0] {
    CIF_ERR_ACTIVE,
    CIF_ERR_PASSIVE,
    CIF_ERR_BUSOFF
  } cif_err_state_t;

endpackage : cif_pkg

//--- verilog/cif_busoff_recovery.sv
`timescale 1ns/10ps
module cif_busoff_recovery
  import cif_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // bit stream
  input wire logic in_busoff,
  input wire logic bit_tick,
  input wire logic rx_bit,
  // result
  output logic recovered
);
  import cif_pkg::*;

  logic [3:0] run_reg;
  logic [7:0] seq_reg;

  // ----------------------------------------------------------------
  // counts runs of 11 recessive bits while bus off
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_reg <= 4'h0;
      seq_reg <= 8'h00;
      recovered <= 1'b0;
    end else begin
      recovered <= 1'b0;
      if (!in_busoff) begin
        run_reg <= 4'h0;
        seq_reg <= 8'h00;
      end else if (bit_tick) begin
        if (!rx_bit) begin
          run_reg <= 4'h0;
        end else if (run_reg == CIF_RECESSIVE_RUN - 4'h1) begin
          run_reg <= 4'h0;
          if (seq_reg == CIF_RECOVERY_RUNS - 8'h01) begin
            seq_reg <= 8'h00;
            recovered <= 1'b1;
          end else begin
            seq_reg <= seq_reg + 8'h01;
          end
        end else begin
          run_reg <= run_reg + 4'h1;
        end
      end
    end
  end

endmodule : cif_busoff_recovery

//--- test/cif_can_bus_model.sv
`timescale 1ns/10ps
module cif_can_bus_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control from the bench
  input wire logic dominant,
  // bus side
  output logic bit_tick,
  output logic rx_bit
);
  logic [1:0] div_reg;

  // one bit time is four clocks, keeps the recovery count short
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg <= 2'h0;
    end else begin
      div_reg <= div_reg + 2'h1;
    end
  end
  assign bit_tick = (div_reg == 2'h3);
  // released bus is pulled recessive
  assign rx_bit = ~dominant;
endmodule : cif_can_bus_model

//--- test/test_can_interrupt_flags.sv
`timescale 1ns/10ps
module test_can_interrupt_flags;
  import cif_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h3;
  logic [31:0] prdata, q;
  logic pready, pslverr, irq, e, bit_tick, rx_bit;
  logic overload_sent = 1'b0;
  logic sleep_mode = 1'b0;
  logic standby_entry = 1'b0;
  logic dom = 1'b0;
  logic [8:0] tec = 9'h000;
  logic [8:0] rec = 9'h000;
  logic [15:0] rxc_p = 16'h0, rxr_p = 16'h0, rfr = 16'h0, rcr = 16'h0, usr = 16'h0, tpr = 16'h0, tpr_q = 16'h0;
  logic [15:0] mbm = 16'hffff;
  int bad_count = 0;
  int n_tests = 0;
  int seed = 54201;
  int cyc = 0;
  int m_flags = 32'h0100;
  int i;
  int lim[6] = '{95, 96, 127, 128, 255, 256};

  always #4 pclk = ~pclk;

  cif_flags dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tec(tec), .rec(rec), .overload_sent(overload_sent), .bit_tick(bit_tick), .rx_bit(rx_bit),
    .sleep_mode(sleep_mode), .standby_entry(standby_entry), .rx_complete_pulse(rxc_p),
    .rx_remote_pulse(rxr_p), .remote_request_reg(rfr), .receive_complete_reg(rcr),
    .unread_status_reg(usr), .transmit_pending_reg(tpr), .irq(irq));

  cif_can_bus_model bus (.pclk(pclk), .presetn(presetn), .dominant(dom), .bit_tick(bit_tick), .rx_bit(rx_bit));

  // ----------------------------------------
  // reference model of the flag register
  // ----------------------------------------
  always @(posedge pclk) begin
    if (presetn) begin
      if (psel && penable && pwrite && paddr == CIF_ADDR_FLAGS) m_flags &= ~int'(pwdata[15:0] & 16'hf911);
      if (rfr == 16'h0) m_flags &= ~32'h0400;
      if ((rcr & ~mbm) == 16'h0) m_flags &= ~32'h0200;
      if (usr == 16'h0) m_flags &= ~32'h0002;
      else m_flags |= 32'h0002;
      if (tec >= 256) m_flags |= 32'h4000;
      if (tec >= 128 || rec >= 128) m_flags |= 32'h2000;
      if (rec >= 96) m_flags |= 32'h1000;
      if (tec >= 96) m_flags |= 32'h0800;
      if (overload_sent && tec < 256) m_flags |= 32'h8000;
      if ((rxr_p & ~mbm) != 16'h0) m_flags |= 32'h0400;
      if ((rxc_p & ~mbm) != 16'h0) m_flags |= 32'h0200;
      if ((tpr_q & ~tpr) != 16'h0) m_flags |= 32'h0001;
      if (sleep_mode && dom) m_flags |= 32'h0010;
      if (standby_entry) m_flags |= 32'h0100;
      tpr_q = tpr;
    end
  end

  task tally_and_finish;
    if (bad_count == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : tally_and_finish

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // one spare edge so the last input change has landed
  task rdf;
    @(posedge pclk);
    apb(1'b0, CIF_ADDR_FLAGS, 32'h0);
    chk(q, m_flags);
  endtask : rdf

  always @(posedge pclk) begin
    cyc++;
    if (cyc > 20000) begin
      bad_count++;
      tally_and_finish;
    end
  end

  // ----------------------------------------
  // stimulus
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rdf;
    chk({31'h0, irq}, 32'h1);
    apb(1'b0, CIF_ADDR_MBOX_MASK, 32'h0);
    chk(q, 32'h0000ffff);
    chk({31'h0, e}, 32'h0);
    apb(1'b0, 12'h020, 32'h0);
    chk({31'h0, e}, 32'h1);
    apb(1'b1, CIF_ADDR_FLAGS, 32'h0000feff);
    rdf;
    apb(1'b1, CIF_ADDR_FLAGS, 32'h00000100);
    rdf;
    chk({31'h0, irq}, 32'h0);
    for (i = 0; i < 18; i++) begin
      tec <= (i < 6) ? 9'(lim[i]) : (i < 12) ? 9'h0 : 9'({$random(seed)} % 300);
      rec <= (i < 6) ? 9'h0 : (i < 12) ? 9'(lim[i-6]) : 9'({$random(seed)} % 200);
      rdf;
      apb(1'b1, CIF_ADDR_FLAGS, 32'h0000f800);
      rdf;
    end
    tec <= 9'h0;
    rec <= 9'h0;
    apb(1'b1, CIF_ADDR_FLAGS, 32'h0000f800);
    @(posedge pclk);
    overload_sent <= 1'b1;
    @(posedge pclk);
    overload_sent <= 1'b0;
    rdf;
    apb(1'b1, CIF_ADDR_IRQ_MASK, 32'h00007fff);
    @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, CIF_ADDR_IRQ_MASK, 32'h0000ffff);
    @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, CIF_ADDR_FLAGS, 32'h00008000);
    tec <= 9'h100;
    repeat (1370 * 4) @(posedge pclk);
    rdf;
    repeat (80 * 4) @(posedge pclk);
    m_flags |= 32'h8000;
    rdf;
    tec <= 9'h0;
    apb(1'b1, CIF_ADDR_FLAGS, 32'h0000ffff);
    mbm = 16'hfffe;
    apb(1'b1, CIF_ADDR_MBOX_MASK, 32'h0000fffe);
    rfr <= 16'h0002;
    rcr <= 16'h0002;
    rxr_p <= 16'h0002;
    rxc_p <= 16'h0002;
    @(posedge pclk);
    rxr_p <= 16'h0;
    rxc_p <= 16'h0;
    rdf;
    rfr <= 16'h0003;
    rcr <= 16'h0003;
    rxr_p <= 16'h0001;
    rxc_p <= 16'h0001;
    @(posedge pclk);
    rxr_p <= 16'h0;
    rxc_p <= 16'h0;
    rdf;
    apb(1'b1, CIF_ADDR_FLAGS, 32'h00000600);
    rfr <= 16'h0002;
    rdf;
    rfr <= 16'h0;
    rcr <= 16'h0002;
    rdf;
    usr <= 16'h0004;
    rdf;
    apb(1'b1, CIF_ADDR_FLAGS, 32'h00000002);
    rdf;
    usr <= 16'h0;
    tpr <= 16'h0003;
    rdf;
    tpr <= 16'h0002;
    rdf;
    apb(1'b1, CIF_ADDR_FLAGS, 32'h00000001);
    dom <= 1'b1;
    repeat (6) @(posedge pclk);
    rdf;
    sleep_mode <= 1'b1;
    repeat (6) @(posedge pclk);
    rdf;
    dom <= 1'b0;
    sleep_mode <= 1'b0;
    repeat (6) @(posedge pclk);
    apb(1'b1, CIF_ADDR_FLAGS, 32'h00000010);
    rdf;
    standby_entry <= 1'b1;
    @(posedge pclk);
    standby_entry <= 1'b0;
    repeat (3) @(posedge pclk);
    rdf;
    chk({31'h0, irq}, 32'h1);
    tally_and_finish;
  end
endmodule : test_can_interrupt_flags
